// ==== pkg/hlp_pkg.sv ====
// Constants, types and field layout for the host list pointer register bank
// Function
// RULE_01: Communication area base low eight bits read zero
// RULE_02: Driver finds alignment by writing ones, reading back
// RULE_03: Bits 31..8 hold writable 24-bit area base
// RULE_04: Shared area holds structures used by both sides
// RULE_05: Periodic pointer bits 31..4 hold descriptor address
// RULE_06: Periodic pointer names head of list this frame
// RULE_07: Controller updates periodic pointer; software only reads
// RULE_08: Driver may read periodic pointer at any time
// RULE_09: Control list walk starts at head pointer address
// RULE_10: Control head loaded from shared area at init
// RULE_11: Software writes reserved bits as zero
// RULE_12: Registers decoded at 18h, 1Ch, 20h from base
// RULE_13: All registers reset zero; pointer bits 3..0 zero
package hlp_pkg;

	// Register offsets inside the function's memory window
	localparam logic [11:0] HLP_OFF_COMM_AREA    = 12'h018;
	localparam logic [11:0] HLP_OFF_PERIODIC     = 12'h01c;
	localparam logic [11:0] HLP_OFF_CTRL_HEAD    = 12'h020;

	// Window size of one function's operational registers, in address bits
	localparam int          HLP_WIN_BITS         = 12;
	localparam int          HLP_ADDR_W           = 32;
	localparam int          HLP_DATA_W           = 32;
	localparam int          HLP_BE_W             = 4;

	// Field layout
	localparam int          HLP_COMM_LSB         = 8;
	localparam int          HLP_COMM_W           = 24;
	localparam int          HLP_PTR_LSB          = 4;
	localparam int          HLP_PTR_W            = 28;

	// Reset values
	localparam logic [31:0] HLP_RESET_WORD       = 32'h0000_0000;
	localparam logic [23:0] HLP_RESET_COMM       = 24'h00_0000;
	localparam logic [27:0] HLP_RESET_PTR        = 28'h000_0000;

	// Byte offset of the control head word inside the shared area
	localparam logic [7:0]  HLP_AREA_HEAD_OFS    = 8'hf0;

	// Response FIFO shape
	localparam int          HLP_FIFO_DEPTH       = 16;

	// Initialisation sequencer
	typedef enum logic [1:0] {
		HLP_INIT_IDLE,
		HLP_INIT_REQ,
		HLP_INIT_WAIT
	} hlp_init_state_t;

endpackage : hlp_pkg

// ==== sim/hlp_lpr_asserts.sv ====
// Port-level checks of the list pointer register bank
`timescale 1ns/10ps
module hlp_lpr_asserts
	import hlp_pkg::*;
#(
	parameter logic FUNC_NUM = 1'b0
) (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic [31:0] mem_base,
	input wire logic        reg_func,
	input wire logic [31:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        reg_ack,
	input wire logic        reg_hit,
	input wire logic        periodic_load,
	input wire logic [27:0] periodic_next_addr,
	input wire logic [31:0] shared_comm_area,
	input wire logic [31:0] periodic_current_addr,
	input wire logic [31:0] control_head_addr,
	input wire logic        init_start,
	input wire logic        init_busy,
	input wire logic        init_done,
	input wire logic        mem_rd_req,
	input wire logic [31:0] mem_rd_addr,
	input wire logic        mem_rd_grant
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Bus answer timing and decode
	a_ack_on_hit: assert property ((reg_wr || reg_rd) && reg_hit |=> reg_ack)
		else $error("hit not acknowledged");
	a_no_stray_ack: assert property (!((reg_wr || reg_rd) && reg_hit) |=> !reg_ack)
		else $error("stray acknowledge");
	a_hit_decode: assert property (reg_hit ==
		(reg_func == FUNC_NUM && reg_addr[31:12] == mem_base[31:12])) else $error("bad decode");
	// Read data matches the copies seen by the list engine
	a_area_read: assert property (reg_rd && reg_hit && reg_addr[11:0] == HLP_OFF_COMM_AREA
		|=> reg_rdata == shared_comm_area) else $error("area read mismatch");
	a_period_read: assert property (reg_rd && reg_hit && reg_addr[11:0] == HLP_OFF_PERIODIC
		|=> reg_rdata == periodic_current_addr) else $error("periodic read mismatch");
	a_area_align: assert property (shared_comm_area[7:0] == 8'h00)
		else $error("area base not aligned");
	a_ptr_low_zero: assert property (((periodic_current_addr | control_head_addr)
		& 32'hf) == 32'h0) else $error("pointer low bits set");
	a_period_load: assert property (periodic_load |=> ##1
		periodic_current_addr == {$past(periodic_next_addr, 2), 4'h0}) else $error("load lost");
	// Control head fetch from the shared area
	a_init_launch: assert property (init_start && !init_busy |=> init_busy && mem_rd_req)
		else $error("fetch not launched");
	a_fetch_addr: assert property (mem_rd_req |->
		mem_rd_addr == {shared_comm_area[31:8], HLP_AREA_HEAD_OFS}) else $error("fetch address");
	a_fetch_done: assert property (mem_rd_req && mem_rd_grant |-> ##[1:40] init_done)
		else $error("fetch never done");
endmodule // hlp_lpr_asserts
bind hlp_list_ptr_regs hlp_lpr_asserts #(.FUNC_NUM(FUNC_NUM)) u_asserts (.*);

// ==== sim/hlp_mem_model.sv ====
// Behavioural system memory answering the control head fetch
`timescale 1ns/10ps
module hlp_mem_model (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        mem_rd_req,
	output logic             mem_rd_grant,
	output logic      [31:0] mem_rd_data,
	output logic             mem_rd_valid,
	input  wire logic        mem_rd_ready,
	input  wire logic [31:0] area_word,
	input  wire logic [3:0]  lag
);
	logic [3:0] cnt;
	logic [1:0] left;
	// Grant one cycle after the request shows, never while a burst is out
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			mem_rd_grant <= 1'b0;
		else
			mem_rd_grant <= mem_rd_req && !mem_rd_grant && left == 2'd0;
	end
	// Shared area sends three words; idle data scrambles so stale values never pass
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			mem_rd_valid <= 1'b0;
			mem_rd_data  <= 32'h0000_0000;
			cnt          <= 4'h0;
			left         <= 2'd0;
		end else if (mem_rd_req && mem_rd_grant) begin
			left <= 2'd3;
			cnt  <= lag;
		end else if (mem_rd_valid && !mem_rd_ready) begin
			// Word stands until the FIFO takes it
		end else if (left != 2'd0 && cnt == 4'h0) begin
			mem_rd_valid <= 1'b1;
			mem_rd_data  <= (left == 2'd3) ? area_word : ~area_word;
			left         <= left - 2'd1;
		end else begin
			mem_rd_valid <= 1'b0;
			mem_rd_data  <= ~mem_rd_data;
			if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
endmodule // hlp_mem_model

// ==== sim/tb_top.sv ====
// Self-checking bench for the list pointer register bank
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_top
	import hlp_pkg::*;
;
	logic        clk_sys, reset_n, reg_func, reg_wr, reg_rd, reg_ack, reg_hit;
	logic        periodic_load, init_start, init_busy, init_done, mem_rd_req;
	logic        mem_rd_grant, mem_rd_valid, mem_rd_ready;
	logic [31:0] mem_base, reg_addr, reg_wdata, reg_rdata, mem_rd_addr, mem_rd_data;
	logic [31:0] shared_comm_area, periodic_current_addr, control_head_addr;
	logic [31:0] area_word, d, area;
	logic [27:0] periodic_next_addr, n;
	logic [3:0]  reg_be, lag, be;
	int          error_cnt, n_tests, cyc, k, j;

	hlp_list_ptr_regs #(.FUNC_NUM(1'b1)) DUT (.*);
	hlp_mem_model u_mem (.*);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Byte-lane merge; the low byte of the area base never sticks
	function automatic logic [31:0] merge(input logic [31:0] o, w, input logic [3:0] e);
		for (int i = 0; i < 4; i++)
			if (e[i]) o[8*i+:8] = w[8*i+:8];
		return {o[31:8], 8'h00};
	endfunction

	// One bus access: strobe for one edge, answer looked at right after
	task automatic acc(input int w, input logic [11:0] o, input logic [31:0] v, x);
		@(posedge clk_sys);
		reg_wr    <= (w != 0);
		reg_rd    <= (w == 0);
		reg_addr  <= mem_base + o;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_ack, 1'b1)
		if (w == 0) `CHK(reg_rdata, x)
	endtask

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Hang guard; the whole run needs well under this
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		{reg_wr, reg_rd, periodic_load, init_start, reset_n} = 5'h0;
		{reg_func, reg_be, lag, reg_addr, reg_wdata} = {1'b1, 4'hf, 4'h0, 64'h0};
		{periodic_next_addr, area_word} = 60'h0;
		d = $urandom(97);
		mem_base = {d[31:12], 12'h000};
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		acc(0, HLP_OFF_COMM_AREA, 0, 0);
		acc(0, HLP_OFF_PERIODIC, 0, 0);
		acc(0, HLP_OFF_CTRL_HEAD, 0, 0);
		acc(0, 12'h024, 0, 0);
		`CHK(mem_rd_ready, 1'b1)
		$display("test reset values done");
		acc(1, HLP_OFF_COMM_AREA, 32'hffff_ffff, 0);
		acc(0, HLP_OFF_COMM_AREA, 0, 32'hffff_ff00);
		area = 32'hffff_ff00;
		for (k = 0; k < 8; k++) begin
			d  = $urandom & 32'hffff_ff00;
			be = 4'($urandom);
			reg_be <= be;
			acc(1, HLP_OFF_COMM_AREA, d, 0);
			area = merge(area, d, be);
			acc(0, HLP_OFF_COMM_AREA, 0, area);
		end
		reg_be <= 4'hf;
		$display("test area base done");
		acc(1, HLP_OFF_PERIODIC, 32'hffff_fff0, 0);
		acc(1, HLP_OFF_CTRL_HEAD, 32'hffff_fff0, 0);
		acc(0, HLP_OFF_PERIODIC, 0, 0);
		acc(0, HLP_OFF_CTRL_HEAD, 0, 0);
		n = 28'($urandom);
		@(posedge clk_sys);
		periodic_load      <= 1'b1;
		periodic_next_addr <= n;
		@(posedge clk_sys);
		periodic_next_addr <= ~n;
		@(posedge clk_sys);
		periodic_load <= 1'b0;
		acc(0, HLP_OFF_PERIODIC, 0, {~n, 4'h0});
		$display("test periodic pointer done");
		@(posedge clk_sys);
		{reg_func, reg_wr} <= 2'b01;
		reg_addr <= mem_base + HLP_OFF_COMM_AREA;
		@(posedge clk_sys);
		{reg_func, reg_wr} <= 2'b10;
		#1;
		`CHK(reg_ack, 1'b0)
		acc(0, HLP_OFF_COMM_AREA, 0, area);
		$display("test decode miss done");
		for (k = 0; k < 2; k++) begin
			area_word <= $urandom;
			lag       <= 4'(k * 5);
			@(posedge clk_sys);
			init_start <= 1'b1;
			@(posedge clk_sys);
			init_start <= 1'b0;
			for (j = 0; j < 50 && init_done !== 1'b1; j++) begin
				@(posedge clk_sys);
				#1;
			end
			`CHK(init_done, 1'b1)
			@(posedge clk_sys);
			#1;
			`CHK(control_head_addr, {area_word[31:4], 4'h0})
			acc(0, HLP_OFF_CTRL_HEAD, 0, {area_word[31:4], 4'h0});
		end
		$display("test head fetch done");
		summarize();
	end
endmodule // tb_top

// ==== verilog/hlp_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module hlp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wr_idx;
	logic [PW-1:0]    rd_idx;
	logic [PW:0]      count;
	logic             push;
	logic             pop;

	// Full and empty come straight from the count, so ready never lies
	assign in_ready  = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = store[rd_idx];

	// Storage write
	always_ff @(posedge clk_sys) begin
		if (push) begin
			store[wr_idx] <= in_data;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			wr_idx <= '0;
			rd_idx <= '0;
		end else begin
			if (push) begin
				wr_idx <= (wr_idx == PW'(DEPTH - 1)) ? '0 : wr_idx + PW'(1);
			end
			if (pop) begin
				rd_idx <= (rd_idx == PW'(DEPTH - 1)) ? '0 : rd_idx + PW'(1);
			end
		end
	end

	// Occupancy
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + (PW+1)'(1);
		end else if (pop && !push) begin
			count <= count - (PW+1)'(1);
		end
	end

endmodule // hlp_fifo

// ==== verilog/hlp_list_ptr_regs.sv ====
// List pointer register bank: shared area base, periodic and control head pointers
`timescale 1ns/10ps
module hlp_list_ptr_regs
	import hlp_pkg::*;
#(
	parameter logic FUNC_NUM = 1'b0
) (
	input  wire logic                  clk_sys,
	input  wire logic                  reset_n,
	// Memory base from configuration offset 10h of this function
	input  wire logic [HLP_ADDR_W-1:0] mem_base,
	// Register access from the PCI target
	input  wire logic                  reg_func,
	input  wire logic [HLP_ADDR_W-1:0] reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [HLP_BE_W-1:0]   reg_be,
	input  wire logic [HLP_DATA_W-1:0] reg_wdata,
	output logic      [HLP_DATA_W-1:0] reg_rdata,
	output logic                       reg_ack,
	output logic                       reg_hit,
	// List engine side
	input  wire logic                  periodic_load,
	input  wire logic [HLP_PTR_W-1:0]  periodic_next_addr,
	output logic      [HLP_ADDR_W-1:0] shared_comm_area,
	output logic      [HLP_ADDR_W-1:0] periodic_current_addr,
	output logic      [HLP_ADDR_W-1:0] control_head_addr,
	input  wire logic                  init_start,
	output logic                       init_busy,
	output logic                       init_done,
	// Memory read toward system memory
	output logic                       mem_rd_req,
	output logic      [HLP_ADDR_W-1:0] mem_rd_addr,
	input  wire logic                  mem_rd_grant,
	input  wire logic [HLP_DATA_W-1:0] mem_rd_data,
	input  wire logic                  mem_rd_valid,
	output logic                       mem_rd_ready
);

	// Register contents, only the implemented fields are stored
	logic [HLP_COMM_W-1:0] comm_area_base;
	logic [HLP_PTR_W-1:0]  periodic_current_desc_ptr;
	logic [HLP_PTR_W-1:0]  control_list_head_ptr;

	hlp_init_state_t       init_state;
	hlp_init_state_t       next_init_state;

	logic                  wr_hit;
	logic                  rd_hit;
	logic                  sel_comm_area;
	logic                  sel_periodic;
	logic                  sel_ctrl_head;
	logic [HLP_DATA_W-1:0] area_merged;
	logic                  head_take;
	logic                  fetch_launch;
	logic                  fetch_granted;
	logic                  init_idle;
	logic [HLP_DATA_W-1:0] next_rdata;
	logic [HLP_DATA_W-1:0] resp_data;
	logic                  resp_valid;
	logic                  resp_pop;

	// True when the address falls inside this function's window
	function automatic logic win_hit(
		input logic                  func,
		input logic [HLP_ADDR_W-1:0] addr,
		input logic [HLP_ADDR_W-1:0] base
	);
		win_hit = (func == FUNC_NUM) &&
			(addr[HLP_ADDR_W-1:HLP_WIN_BITS] == base[HLP_ADDR_W-1:HLP_WIN_BITS]);
	endfunction

	// Offset of an access inside the window
	function automatic logic [HLP_WIN_BITS-1:0] win_ofs(
		input logic [HLP_ADDR_W-1:0] addr
	);
		win_ofs = addr[HLP_WIN_BITS-1:0];
	endfunction

	// True when an access lands on the given register offset
	function automatic logic ofs_sel(
		input logic [HLP_ADDR_W-1:0]   addr,
		input logic [HLP_WIN_BITS-1:0] ofs
	);
		ofs_sel = (win_ofs(addr) == ofs);
	endfunction

	// Merge write data into a word under byte enables
	function automatic logic [HLP_DATA_W-1:0] be_merge(
		input logic [HLP_DATA_W-1:0] old_word,
		input logic [HLP_DATA_W-1:0] new_word,
		input logic [HLP_BE_W-1:0]   be
	);
		logic [HLP_DATA_W-1:0] res;
		res = old_word;
		for (int i = 0; i < HLP_BE_W; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		be_merge = res;
	endfunction

	// Widen a pointer field back to a word with zeroed low bits
	function automatic logic [HLP_DATA_W-1:0] ptr_word(
		input logic [HLP_PTR_W-1:0] ptr
	);
		ptr_word = {ptr, {HLP_PTR_LSB{1'b0}}};
	endfunction

	// Window decode shared by reads and writes
	assign reg_hit = win_hit(reg_func, reg_addr, mem_base); // RULE_12
	assign wr_hit  = reg_wr && reg_hit;
	assign rd_hit  = reg_rd && reg_hit;

	// Offset selects, decoded once for the write and read paths
	assign sel_comm_area = ofs_sel(reg_addr, HLP_OFF_COMM_AREA);
	assign sel_periodic  = ofs_sel(reg_addr, HLP_OFF_PERIODIC);
	assign sel_ctrl_head = ofs_sel(reg_addr, HLP_OFF_CTRL_HEAD);

	// Byte-lane merge of a write into the current area base word
	assign area_merged = be_merge({comm_area_base, {HLP_COMM_LSB{1'b0}}}, reg_wdata, reg_be);

	// Communication area base, low byte never stored so it cannot read back as one
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			comm_area_base <= HLP_RESET_COMM; // RULE_13
		end else if (wr_hit && sel_comm_area) begin
			comm_area_base <= area_merged[HLP_DATA_W-1:HLP_COMM_LSB]; // RULE_03
		end
	end

	// Periodic pointer moves only under the engine; bus writes are dropped
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			periodic_current_desc_ptr <= HLP_RESET_PTR; // RULE_13
		end else if (periodic_load) begin
			periodic_current_desc_ptr <= periodic_next_addr; // RULE_07
		end
	end

	// Control head is read-only on the bus and filled by the init fetch
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			control_list_head_ptr <= HLP_RESET_PTR; // RULE_13
		end else if (head_take) begin
			control_list_head_ptr <= resp_data[HLP_DATA_W-1:HLP_PTR_LSB]; // RULE_10
		end
	end

	// Read mux; unmapped offsets in the window read as zero
	always_comb begin
		next_rdata = HLP_RESET_WORD;
		if (sel_comm_area) begin
			next_rdata = {comm_area_base, {HLP_COMM_LSB{1'b0}}}; // RULE_01
		end else if (sel_periodic) begin
			next_rdata = ptr_word(periodic_current_desc_ptr); // RULE_05
		end else if (sel_ctrl_head) begin
			next_rdata = ptr_word(control_list_head_ptr); // RULE_09
		end else begin
			next_rdata = HLP_RESET_WORD;
		end
	end

	// Read data is registered, so the ack lands one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			reg_rdata <= HLP_RESET_WORD;
		end else if (rd_hit) begin
			reg_rdata <= next_rdata; // RULE_08
		end
	end

	// Every hit, read or write, is acknowledged exactly once
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			reg_ack <= 1'b0;
		end else begin
			reg_ack <= rd_hit || wr_hit;
		end
	end

	// Area base copy toward the list engine, one cycle behind the register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			shared_comm_area <= HLP_RESET_WORD;
		end else begin
			shared_comm_area <= {comm_area_base, {HLP_COMM_LSB{1'b0}}}; // RULE_04
		end
	end

	// Periodic pointer copy toward the list engine
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			periodic_current_addr <= HLP_RESET_WORD;
		end else begin
			periodic_current_addr <= ptr_word(periodic_current_desc_ptr); // RULE_06
		end
	end

	// Control head copy, where the engine starts its control list walk
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			control_head_addr <= HLP_RESET_WORD;
		end else begin
			control_head_addr <= ptr_word(control_list_head_ptr); // RULE_09
		end
	end

	// Read responses from memory queue here; the sequencer drains while idle or
	// waiting, so a sequencer stalled in the request state pushes back on the memory side
	hlp_fifo #(
		.WIDTH (HLP_DATA_W),
		.DEPTH (HLP_FIFO_DEPTH)
	) u_resp_fifo (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.in_data   (mem_rd_data),
		.in_valid  (mem_rd_valid),
		.in_ready  (mem_rd_ready),
		.out_data  (resp_data),
		.out_valid (resp_valid),
		.out_ready (resp_pop)
	);

	// Stale words left over from an earlier fetch are flushed while idle,
	// so the next fetch loads a fresh word unless it launches before the idle flush has emptied the queue
	assign resp_pop = (init_state == HLP_INIT_WAIT) || init_idle;

	// Sequencer events shared by the state, request and status logic
	assign init_idle     = (init_state == HLP_INIT_IDLE);
	assign fetch_launch  = init_idle && init_start;
	assign fetch_granted = (init_state == HLP_INIT_REQ) && mem_rd_grant;
	assign head_take     = (init_state == HLP_INIT_WAIT) && resp_valid;

	// Init sequencer next state
	always_comb begin
		next_init_state = init_state;
		case (init_state)
			HLP_INIT_IDLE: begin
				if (init_start) begin
					next_init_state = HLP_INIT_REQ;
				end
			end
			HLP_INIT_REQ: begin
				if (mem_rd_grant) begin
					next_init_state = HLP_INIT_WAIT;
				end
			end
			HLP_INIT_WAIT: begin
				if (resp_valid) begin
					next_init_state = HLP_INIT_IDLE;
				end
			end
			default: begin
				next_init_state = HLP_INIT_IDLE;
			end
		endcase
	end

	// Init sequencer state
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			init_state <= HLP_INIT_IDLE;
		end else begin
			init_state <= next_init_state;
		end
	end

	// Fetch request held until granted
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			mem_rd_req <= 1'b0;
		end else if (fetch_launch) begin
			mem_rd_req <= 1'b1; // RULE_10
		end else if (fetch_granted) begin
			mem_rd_req <= 1'b0;
		end
	end

	// Fetch address latched at launch, so a later base write cannot move it
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			mem_rd_addr <= HLP_RESET_WORD;
		end else if (fetch_launch) begin
			mem_rd_addr <= {comm_area_base, HLP_AREA_HEAD_OFS}; // RULE_10
		end
	end

	// Init status toward the engine
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			init_done <= 1'b0;
		end else begin
			init_done <= head_take;
		end
	end

	assign init_busy = !init_idle;

endmodule // hlp_list_ptr_regs
